// ==== rtl/rhc_pkg.sv ====
// shared constants and types for the rheostat command chain
package rhc_pkg;
    localparam int          FRAME_BITS      = 16;
    localparam int          CMD_HI          = 13;
    localparam int          CMD_LO          = 10;
    localparam int          WIPER_BITS      = 10;
    localparam int          ADDR_BITS       = 6;
    localparam int          CTRL_BITS       = 10;
    localparam logic [5:0]  OTP_LOCATIONS   = 6'h32;
    localparam logic [5:0]  OTP_FIRST_ADDR  = 6'h01;
    localparam logic [9:0]  WIPER_MIDSCALE  = 10'h200;
    localparam logic [15:0] SDO_RELEASE_WORD = 16'h8001;
    // control flag positions
    localparam int          FLAG_PROG_EN    = 0;
    localparam int          FLAG_UNLOCK     = 1;
    localparam int          FLAG_CAL_DIS    = 2;
    localparam int          FLAG_SUCCESS    = 3;
    // store lock time
    localparam longint      PROG_TIME_MS    = 350;
    localparam longint      CLK_HZ          = 20000000;
    localparam longint      PROG_CYCLES     = PROG_TIME_MS * CLK_HZ / 1000;

    typedef enum logic [3:0] {
        RHC_NOP        = 4'h0,
        RHC_WR_WIPER   = 4'h1,
        RHC_RD_WIPER   = 4'h2,
        RHC_STORE      = 4'h3,
        RHC_RESET      = 4'h4,
        RHC_RD_OTP     = 4'h5,
        RHC_RD_LAST    = 4'h6,
        RHC_WR_CTRL    = 4'h7,
        RHC_RD_CTRL    = 4'h8,
        RHC_SHUTDOWN   = 4'h9
    } rhc_cmd_t;

    // what the next output frame carries
    typedef enum logic [4:0] {
        RHC_RB_ECHO  = 5'b00001,
        RHC_RB_WIPER = 5'b00010,
        RHC_RB_OTP   = 5'b00100,
        RHC_RB_LAST  = 5'b01000,
        RHC_RB_CTRL  = 5'b10000
    } rhc_rb_t;

    function automatic logic [15:0] rhc_pad_wiper(input logic [9:0] v);
        return {6'h00, v};
    endfunction : rhc_pad_wiper
endpackage : rhc_pkg

// ==== rtl/rhc_sync.sv ====
// two-flop synchroniser for a level
module rhc_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic meta_d;
    logic out_d;

    always_comb begin
        meta_d = din;
        out_d  = meta_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= meta_d;
            dout   <= out_d;
        end
    end
endmodule : rhc_sync

// ==== rtl/rhc_link.sv ====
// serial link shifter on the link clock: frame capture and output shift
module rhc_link (
    // link clock and pins
    input  wire logic        sclk,
    input  wire logic        rst_n,
    input  wire logic        sync_n,
    input  wire logic        din,
    output logic             sdo_oe,
    // words from and to the core
    output logic [15:0]      rx_word,
    output logic             rx_bad,
    input  wire logic [15:0] tx_word,
    input  wire logic        tx_release
);
    import rhc_pkg::*;

    logic [15:0] sh_q;
    logic [15:0] sh_d;
    logic [15:0] out_q;
    logic [15:0] out_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic        first_q;
    logic        first_d;
    logic        oe_d;
    logic        arm_n;

    // sclk stands still between frames, so sync_n itself arms the frame start
    assign arm_n = rst_n & ~sync_n;

    // input sampled on rising edge; output word loaded at frame start
    always_comb begin
        sh_d    = {sh_q[14:0], din};
        cnt_d   = (cnt_q == 5'(FRAME_BITS - 1)) ? 5'h00 : cnt_q + 5'h01;
        first_d = 1'b0;
        // din trails the outgoing word, so a second device sees this frame
        out_d   = first_q ? {tx_word[14:0], din} : {out_q[14:0], din};
        // open drain: enable only while pulling low
        oe_d    = ~tx_release & ~(first_q ? tx_word[15] : out_q[15]);
        if (first_q) begin
            cnt_d = 5'h01;
        end
        // count kept over the gap so a short frame stays visible
        if (sync_n) begin
            cnt_d   = cnt_q;
            first_d = 1'b1;
            sh_d    = sh_q;
            out_d   = out_q;
            oe_d    = 1'b0;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q    <= 16'h0000;
            out_q   <= 16'h0000;
            cnt_q   <= 5'h00;
            sdo_oe  <= 1'b0;
        end else begin
            sh_q    <= sh_d;
            out_q   <= out_d;
            cnt_q   <= cnt_d;
            sdo_oe  <= oe_d;
        end
    end

    // derived reset only raises the flag, so a glitch in the gap is harmless
    always_ff @(posedge sclk or negedge arm_n) begin
        if (!arm_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= first_d;
        end
    end

    // words stay stable while sync_n high; core samples after synchronising
    assign rx_word = sh_q;
    assign rx_bad  = (cnt_q != 5'h00);
endmodule : rhc_link

// ==== rtl/rhc_core.sv ====
// command interpreter of the serially controlled rheostat
// Contract
// - shutdown command with bit0 set enters shutdown
// - all commands still execute during shutdown
// - shutdown bit0 clear or reset leaves shutdown
// - reset loads wiper from last stored value
// - reset loads midscale when nothing stored
// - control word ten bits, flags low four
// - program enable defaults 0, gates stores
// - unlock defaults 0, gates wiper writes
// - calibration disable defaults 0
// - success flag set after completed store
// - six data bits select stored location
// - wiper read returns wiper next frame
// - last address read returns address next frame
// - control read returns flags next frame
// - output changes on rising clock, else echo
// - output only pulls low or releases
// - release word then nop frees output
// - control write 0x1C03 sets enable flags
// - frames multiples of 16, decode at sync
// - command codes zero through nine decoded
// - wiper writes ignored while locked
// - store uses next location, locks input
module rhc_core #(
    parameter longint PROG_WAIT = rhc_pkg::PROG_CYCLES
) (
    // system clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // serial link
    input  wire logic        sclk,
    input  wire logic        sync_n,
    input  wire logic        din,
    output logic             sdo_o,
    output logic             sdo_oe,
    // analog controls
    output logic [9:0]       wiper_position_reg,
    output logic             shutdown,
    output logic             tolerance_cal_disable,
    output logic             otp_busy
);
    import rhc_pkg::*;

    // link words and frame activity on clk
    logic [15:0] rx_word;
    logic        rx_bad;
    logic        sync_s;
    logic        sync_s_q;
    logic        rise;
    logic        take;

    // otp store and control state
    logic [9:0]  otp_mem [OTP_FIRST_ADDR:OTP_LOCATIONS];
    logic [5:0]  last_q;
    logic [5:0]  last_d;
    logic [9:0]  wiper_d;
    logic        sd_d;
    logic        cal_d;
    logic        pe_q;
    logic        pe_d;
    logic        unl_q;
    logic        unl_d;
    logic        ok_q;
    logic        ok_d;
    logic [15:0] tx_q;
    logic [15:0] tx_d;
    logic        release_q;
    logic        release_d;
    logic        arm_q;
    logic        arm_d;
    logic [31:0] wait_q;
    logic [31:0] wait_d;
    logic        busy_d;
    logic        do_store;
    rhc_cmd_t    cmd;
    logic [9:0]  data;
    logic [9:0]  ctrl_word;

    // tx_q and release_q only move after a frame, well before the next one starts
    rhc_link u_link (
        .sclk       (sclk),
        .rst_n      (rst_n),
        .sync_n     (sync_n),
        .din        (din),
        .sdo_oe     (sdo_oe),
        .rx_word    (rx_word),
        .rx_bad     (rx_bad),
        .tx_word    (tx_q),
        .tx_release (release_q)
    );

    // frame activity is idle low, matching the reset value: no false commit
    rhc_sync u_sync (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (~sync_n),
        .dout (sync_s)
    );

    // rx_word is quiescent while sync_n high, so sampling after sync is safe
    assign rise      = ~sync_s & sync_s_q;
    assign take      = rise & ~rx_bad & ~otp_busy;
    assign cmd       = rhc_cmd_t'(rx_word[CMD_HI:CMD_LO]);
    assign data      = rx_word[WIPER_BITS-1:0];
    assign ctrl_word = {6'h00, ok_q, tolerance_cal_disable, unl_q, pe_q};

    always_comb begin
        wiper_d   = wiper_position_reg;
        sd_d      = shutdown;
        cal_d     = tolerance_cal_disable;
        pe_d      = pe_q;
        unl_d     = unl_q;
        ok_d      = ok_q;
        last_d    = last_q;
        tx_d      = tx_q;
        release_d = release_q;
        arm_d     = arm_q;
        wait_d    = (wait_q != 32'h0) ? wait_q - 32'h1 : 32'h0;
        busy_d    = (wait_d != 32'h0);
        do_store  = 1'b0;
        if (wait_q == 32'h1 && last_q != 6'h00) begin
            ok_d = 1'b1;
        end
        // frames during programming are dropped: input locked
        if (rise && !rx_bad && !otp_busy) begin
            tx_d  = rx_word;
            arm_d = (rx_word == SDO_RELEASE_WORD);
            if (arm_q && cmd == RHC_NOP) begin
                release_d = 1'b1;
            end else if (cmd != RHC_NOP) begin
                release_d = 1'b0;
            end
            case (cmd)
                RHC_WR_WIPER: begin
                    if (unl_q) begin
                        wiper_d = data;
                    end
                end
                RHC_RD_WIPER: tx_d = rhc_pad_wiper(wiper_position_reg);
                RHC_STORE: begin
                    if (pe_q && last_q != OTP_LOCATIONS) begin
                        do_store = 1'b1;
                        last_d   = last_q + OTP_FIRST_ADDR;
                        ok_d     = 1'b0;
                        wait_d   = 32'(PROG_WAIT);
                        busy_d   = 1'b1;
                    end
                end
                RHC_RESET: begin
                    sd_d    = 1'b0;
                    wiper_d = (last_q == 6'h00) ? WIPER_MIDSCALE : otp_mem[last_q];
                end
                RHC_RD_OTP: begin
                    if (data[ADDR_BITS-1:0] != 6'h00 && data[ADDR_BITS-1:0] <= OTP_LOCATIONS) begin
                        tx_d = rhc_pad_wiper(otp_mem[data[ADDR_BITS-1:0]]);
                    end else begin
                        tx_d = 16'h0000;
                    end
                end
                RHC_RD_LAST: tx_d = {10'h000, last_q};
                RHC_WR_CTRL: begin
                    pe_d  = data[FLAG_PROG_EN];
                    unl_d = data[FLAG_UNLOCK];
                    cal_d = data[FLAG_CAL_DIS];
                end
                RHC_RD_CTRL: tx_d = {6'h00, ctrl_word};
                RHC_SHUTDOWN: sd_d = data[0];
                default: ;
            endcase
        end
    end

    // store array has no reset, like a fuse bank initial state
    always_ff @(posedge clk) begin
        if (do_store) begin
            otp_mem[last_d] <= wiper_position_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wiper_position_reg    <= WIPER_MIDSCALE;
            shutdown              <= 1'b0;
            tolerance_cal_disable <= 1'b0;
            pe_q                  <= 1'b0;
            unl_q                 <= 1'b0;
            ok_q                  <= 1'b0;
            last_q                <= 6'h00;
            tx_q                  <= 16'h0000;
            release_q             <= 1'b0;
            arm_q                 <= 1'b0;
            wait_q                <= 32'h0;
            otp_busy              <= 1'b0;
            sync_s_q              <= 1'b0;
            sdo_o                 <= 1'b0;
        end else begin
            wiper_position_reg    <= wiper_d;
            shutdown              <= sd_d;
            tolerance_cal_disable <= cal_d;
            pe_q                  <= pe_d;
            unl_q                 <= unl_d;
            ok_q                  <= ok_d;
            last_q                <= last_d;
            tx_q                  <= tx_d;
            release_q             <= release_d;
            arm_q                 <= arm_d;
            wait_q                <= wait_d;
            otp_busy              <= busy_d;
            sync_s_q              <= sync_s;
            sdo_o                 <= 1'b0;
        end
    end

    shutdown_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !rx_bad && !otp_busy && cmd == RHC_SHUTDOWN |=> shutdown == $past(data[0]))
        else $error("shutdown not following command");
    reset_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !rx_bad && !otp_busy && cmd == RHC_RESET |=> !shutdown)
        else $error("reset left shutdown set");
    reset_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !rx_bad && !otp_busy && cmd == RHC_RESET && last_q == 6'h00
        |=> wiper_position_reg == WIPER_MIDSCALE)
        else $error("reset without store not midscale");
    lock_wiper_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && cmd == RHC_WR_WIPER && !unl_q |=> $stable(wiper_position_reg))
        else $error("locked wiper changed");
    store_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pe_q |=> last_q == $past(last_q))
        else $error("store while disabled");
    store_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        last_q <= OTP_LOCATIONS)
        else $error("store address past end");
    store_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        last_q != $past(last_q) |-> otp_busy ##1 otp_busy)
        else $error("store not locking input");
    rd_wiper_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !rx_bad && !otp_busy && cmd == RHC_RD_WIPER
        |=> tx_q == rhc_pad_wiper($past(wiper_position_reg)))
        else $error("wiper readback wrong");
    rd_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !rx_bad && !otp_busy && cmd == RHC_RD_CTRL |=> tx_q[15:4] == 12'h000)
        else $error("control readback upper bits set");

    // reset, shutdown, control write, readback, release, store lock and frame checks
    reset_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_RESET && last_q != 6'h00 |=> wiper_position_reg == otp_mem[$past(last_q)])
        else $error("reset did not load last stored value");
    sd_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && shutdown && cmd == RHC_WR_WIPER && unl_q |=> wiper_position_reg == $past(data))
        else $error("wiper write lost in shutdown");
    ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_WR_CTRL |=> pe_q == $past(data[FLAG_PROG_EN]) && unl_q == $past(data[FLAG_UNLOCK]))
        else $error("control enables not written");
    cal_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_WR_CTRL |=> tolerance_cal_disable == $past(data[FLAG_CAL_DIS]))
        else $error("calibration flag not written");
    success_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        wait_q == 32'h1 |=> ok_q && !otp_busy)
        else $error("success flag not set after store");
    store_next_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_STORE && pe_q && last_q != OTP_LOCATIONS
        |=> otp_busy && !ok_q && last_q == $past(last_q) + OTP_FIRST_ADDR)
        else $error("store did not take next location");
    full_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_STORE && last_q == OTP_LOCATIONS |=> !otp_busy && $stable(ok_q))
        else $error("store accepted when full");
    busy_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && otp_busy |=> $stable(wiper_position_reg) && $stable(tx_q))
        else $error("frame accepted during store lock");
    bad_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise && rx_bad |=> $stable(wiper_position_reg) && $stable(tx_q))
        else $error("short frame was decoded");
    echo_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_NOP |=> tx_q == $past(rx_word))
        else $error("input word not echoed");
    release_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_NOP && arm_q |=> release_q)
        else $error("output not released");
    rearm_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd != RHC_NOP |=> !release_q)
        else $error("output still released after command");
    rd_last_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_RD_LAST |=> tx_q == {10'h000, $past(last_q)})
        else $error("last address readback wrong");
    rd_ctrl_val_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_RD_CTRL |=> tx_q[3:0] == $past({ok_q, tolerance_cal_disable, unl_q, pe_q}))
        else $error("control readback flags wrong");
    rd_otp_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_RD_OTP && data[ADDR_BITS-1:0] == 6'h00 |=> tx_q == 16'h0000)
        else $error("reserved location read not zero");
    rd_otp_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_RD_OTP && data[ADDR_BITS-1:0] == OTP_FIRST_ADDR && last_q != 6'h00
        |=> tx_q == rhc_pad_wiper(otp_mem[OTP_FIRST_ADDR]))
        else $error("first stored location readback wrong");

    // main scenarios
    cv_store_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(ok_q));
    cv_release_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(release_q));
    cv_sd_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(shutdown));
    cv_full_c: cover property (@(posedge clk) disable iff (!rst_n)
        take && cmd == RHC_STORE && last_q == OTP_LOCATIONS);
    cv_bad_c: cover property (@(posedge clk) disable iff (!rst_n) rise && rx_bad);
endmodule : rhc_core

// ==== sim/rhc_host.sv ====
// spi host model that frames words into the rheostat core
module rhc_host (
    // link pins
    output logic      sclk,
    output logic      sync_n,
    output logic      din,
    input  wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 100ps;

    // 6 ns link period; the clock stands still low between frames
    initial begin
        sclk   = 1'b0;
        sync_n = 1'b1;
        din    = 1'b0;
    end

    task automatic shift(input logic [31:0] w, input int n, output logic [31:0] r);
        r      = '0;
        sync_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din = w[i];
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
            r = {r[30:0], sdo_line};
        end
        #3 sync_n = 1'b1;
        // released data line must not look like the last bit
        din = ~din;
        // commit takes about 3 clk, plus the 5 clk gap before the next fall
        #400;
    endtask : shift

    task automatic xfer16(input logic [15:0] w, output logic [15:0] r);
        logic [31:0] r32;
        shift({16'h0000, w}, 16, r32);
        r = r32[15:0];
    endtask : xfer16

    task automatic xfer32(input logic [31:0] w, output logic [31:0] r);
        shift(w, 32, r);
    endtask : xfer32
endmodule : rhc_host

// ==== sim/tb.sv ====
// self-checking bench for the rheostat command core
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rhc_pkg::*;

    localparam longint PROG_W = 20;

    logic       clk;
    logic       rst_n;
    logic       sclk;
    logic       sync_n;
    logic       din;
    logic       sdo_o;
    logic       sdo_oe;
    logic [9:0] wiper_position_reg;
    logic       shutdown;
    logic       tolerance_cal_disable;
    logic       otp_busy;
    logic [15:0] rd;
    logic [31:0] rd32;
    int         n_mismatch = 0;
    int         checked    = 0;
    // open drain with pull-up
    wire logic  sdo_line = sdo_oe ? sdo_o : 1'b1;

    rhc_core #(.PROG_WAIT(PROG_W)) u_dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .din(din),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_position_reg(wiper_position_reg),
        .shutdown(shutdown), .tolerance_cal_disable(tolerance_cal_disable),
        .otp_busy(otp_busy));

    rhc_host u_host (.sclk(sclk), .sync_n(sync_n), .din(din), .sdo_line(sdo_line));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic send(input logic [15:0] w);
        @(posedge clk);
        #1;
        u_host.xfer16(w, rd);
    endtask : send

    task automatic chk_wiper(input logic [9:0] exp);
        chk({6'h00, wiper_position_reg}, {6'h00, exp});
    endtask : chk_wiper

    // bounded wait for the store lock to end
    task automatic wait_idle;
        for (int i = 0; i < 200 && otp_busy !== 1'b0; i++) @(posedge clk);
        chk({15'h0, otp_busy}, 16'h0000);
    endtask : wait_idle

    task automatic t_reset_state;
        chk_wiper(WIPER_MIDSCALE);
        chk({13'h0, shutdown, tolerance_cal_disable, otp_busy}, 16'h0000);
        send(16'h2000);
        send(16'h0000);
        chk({6'h00, rd[9:0]}, 16'h0000);
    endtask : t_reset_state

    task automatic t_locked;
        send(16'h0555);
        chk_wiper(WIPER_MIDSCALE);
        send(16'h0c00);
        chk({15'h0, otp_busy}, 16'h0000);
        send(16'h1000);
        chk_wiper(WIPER_MIDSCALE);
    endtask : t_locked

    task automatic t_store;
        send(16'h1c03);
        send(16'h2000);
        send(16'h0000);
        chk({12'h0, rd[3:0]}, 16'h0003);
        send(16'h0500);
        chk_wiper(10'h100);
        send(16'h0800);
        send(16'h0000);
        chk({6'h00, rd[9:0]}, 16'h0100);
        send(16'h0c00);
        chk({15'h0, otp_busy}, 16'h0001);
        send(16'h0477);
        chk_wiper(10'h100);
        wait_idle();
        send(16'h2000);
        send(16'h0000);
        chk({12'h0, rd[3:0]}, 16'h000b);
        send(16'h1800);
        send(16'h0000);
        chk({10'h0, rd[5:0]}, 16'h0001);
        send(16'h1401);
        send(16'h0000);
        chk({6'h00, rd[9:0]}, 16'h0100);
        send(16'h0455);
        send(16'h1000);
        chk_wiper(10'h100);
    endtask : t_store

    task automatic t_shutdown;
        send(16'h2401);
        chk({15'h0, shutdown}, 16'h0001);
        send(16'h04aa);
        chk_wiper(10'h0aa);
        send(16'h2400);
        chk({15'h0, shutdown}, 16'h0000);
        send(16'h2401);
        send(16'h1000);
        chk({15'h0, shutdown}, 16'h0000);
        chk_wiper(10'h100);
    endtask : t_shutdown

    task automatic t_cal_chain;
        send(16'h1c07);
        chk({15'h0, tolerance_cal_disable}, 16'h0001);
        send(16'h1c03);
        chk({15'h0, tolerance_cal_disable}, 16'h0000);
        send(16'h04cc);
        send(16'h0000);
        chk(rd, 16'h04cc);
        @(posedge clk);
        #1;
        u_host.xfer32(32'h0433_0466, rd32);
        chk_wiper(10'h066);
        chk(rd32[15:0], 16'h0433);
        @(posedge clk);
        #1;
        u_host.shift(32'h0000_0477, 17, rd32);
        chk_wiper(10'h066);
    endtask : t_cal_chain

    task automatic t_release;
        send(16'h8001);
        send(16'h0000);
        send(16'h0000);
        chk(rd, 16'hffff);
        send(16'h2000);
        send(16'h0000);
        chk(rd, 16'h000b);
    endtask : t_release

    // fill every stored location, then one store too many
    task automatic t_full;
        for (int i = 0; i < 49; i++) begin
            send(16'h0c00);
            wait_idle();
        end
        send(16'h1800);
        send(16'h0000);
        chk({10'h0, rd[5:0]}, {10'h0, OTP_LOCATIONS});
        send(16'h0c00);
        chk({15'h0, otp_busy}, 16'h0000);
    endtask : t_full

    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        t_reset_state();
        t_locked();
        t_store();
        t_shutdown();
        t_cal_chain();
        t_release();
        t_full();
        final_report();
    end

    // whole run needs well under half of this
    initial begin
        #1000000;
        n_mismatch++;
        final_report();
    end
endmodule : tb
